// >>> design/ssw_top.sv
// Supply supervisor: reset generation, early warning, watchdog and chip-select gating.
`timescale 1ns/1ps
module ssw_top #(
	parameter logic [ssw_pkg::CNT_W-1:0] RST_STRETCH_TICKS = ssw_pkg::CNT_W'(ssw_pkg::RST_STRETCH_TICKS),
	parameter logic [ssw_pkg::CNT_W-1:0] WD_TIMEOUT_TICKS = ssw_pkg::CNT_W'(ssw_pkg::WD_TIMEOUT_TICKS),
	parameter logic [ssw_pkg::CNT_W-1:0] WD_PULSE_TICKS = ssw_pkg::CNT_W'(ssw_pkg::WD_PULSE_TICKS)
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic threshold_select_high,
	input wire logic supply_below_reset,
	input wire logic supply_below_warn,
	input wire logic early_warning_sense_low,
	input wire logic reset_in_low,
	input wire logic manual_reset_in_n,
	input wire logic kick_input,
	input wire logic overvoltage_sense,
	input wire logic timeout_select,
	input wire logic [ssw_pkg::CNT_W-1:0] wd_alt_ticks,
	input wire logic ce_in_n,
	output logic reset_out_n,
	output logic reset_out,
	output logic early_power_warning_n,
	output logic watchdog_pulse_out_n,
	output logic watchdog_fault_out_n,
	output logic overvoltage_flag_n,
	output logic ce_out_n
);
	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers and prescaler.
	logic [ssw_pkg::SYNC_W-1:0] sync_in;
	logic [ssw_pkg::SYNC_W-1:0] sync_out;
	logic tick;
	logic ov_s;
	assign sync_in = {threshold_select_high, supply_below_reset, supply_below_warn,
		early_warning_sense_low, reset_in_low, manual_reset_in_n, kick_input};

	ssw_sync #(.W(ssw_pkg::SYNC_W), .INIT(7'h06)) u_sync ( // [RL21]
		.mclk(mclk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.d(sync_in),
		.q(sync_out)
	);

	ssw_sync #(.W(1), .INIT(1'h0)) u_sync_ov ( // [RL21]
		.mclk(mclk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.d(overvoltage_sense),
		.q(ov_s)
	);

	ssw_prescaler u_presc ( // [RL21]
		.mclk(mclk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.tick(tick)
	);

	wire logic mode_ext = sync_out[6];
	wire logic sup_low_s = sync_out[5];
	wire logic sup_warn_s = sync_out[4];
	wire logic ew_low_s = sync_out[3];
	wire logic rin_low_s = sync_out[2];
	wire logic mr_n_s = sync_out[1];
	wire logic kick_s = sync_out[0];

	////////////////////////////////////////////////////////////////////////////////
	// Threshold decisions.
	wire logic below_rst = mode_ext ? rin_low_s : sup_low_s; // [RL1] [RL3] [RL4]
	// Internal warning also covers the reset trip, so it can never come later.
	wire logic below_warn = mode_ext ? ew_low_s : (sup_warn_s | sup_low_s); // [RL2] [RL3]
	wire logic rst_cause = below_rst | ~mr_n_s; // [RL4] [RL5]

	////////////////////////////////////////////////////////////////////////////////
	// Reset stretch.
	logic rst_active_reg;
	logic [ssw_pkg::CNT_W-1:0] stretch_cnt_reg;
	wire logic stretch_done = tick && (stretch_cnt_reg == RST_STRETCH_TICKS - 1'b1);
	wire logic rst_next = rst_cause | (rst_active_reg & ~stretch_done); // [RL6]
	wire logic [ssw_pkg::CNT_W-1:0] stretch_cnt_next =
		(rst_cause || !rst_active_reg) ? '0 : (tick ? stretch_cnt_reg + 1'b1 : stretch_cnt_reg);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_active_reg <= ssw_pkg::RST_ACTIVE_INIT;
			stretch_cnt_reg <= '0;
			reset_out_n <= 1'b0;
			reset_out <= 1'b1;
			early_power_warning_n <= 1'b0;
			overvoltage_flag_n <= 1'b1;
		end else if (clk_en) begin
			rst_active_reg <= rst_next;
			stretch_cnt_reg <= stretch_cnt_next;
			reset_out_n <= ~rst_next; // [RL9]
			reset_out <= rst_next; // [RL9]
			early_power_warning_n <= ~below_warn; // [RL2]
			overvoltage_flag_n <= ~ov_s; // [RL10]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog timer, pulse and fault.
	logic kick_d_reg;
	logic [ssw_pkg::CNT_W-1:0] wd_cnt_reg;
	logic [ssw_pkg::CNT_W-1:0] wdp_cnt_reg;
	logic pulse_reg;
	logic fault_reg;
	logic [ssw_pkg::FAULT_DELAY_CYCLES-1:0] fd_reg;
	wire logic kick_edge = kick_s ^ kick_d_reg; // [RL12]
	wire logic [ssw_pkg::CNT_W-1:0] wd_limit =
		timeout_select ? wd_alt_ticks : WD_TIMEOUT_TICKS; // [RL14]
	wire logic wd_expire = tick && !kick_edge && (wd_cnt_reg == wd_limit - 1'b1); // [RL11]
	wire logic wdp_end = pulse_reg && tick && (wdp_cnt_reg == WD_PULSE_TICKS - 1'b1);
	wire logic fault_set = fd_reg[ssw_pkg::FAULT_DELAY_CYCLES-1];
	wire logic [ssw_pkg::CNT_W-1:0] wd_cnt_next =
		(kick_edge || wd_expire) ? '0 : (tick ? wd_cnt_reg + 1'b1 : wd_cnt_reg);
	wire logic pulse_next = wd_expire | (pulse_reg & ~wdp_end); // [RL18]
	wire logic [ssw_pkg::CNT_W-1:0] wdp_cnt_next =
		(!pulse_reg || wd_expire) ? '0 : (tick ? wdp_cnt_reg + 1'b1 : wdp_cnt_reg);
	// A fault arriving with a kick edge in the same cycle still wins.
	wire logic fault_next = fault_set | (fault_reg & ~kick_edge); // [RL16] [RL17]

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			kick_d_reg <= 1'b0;
			wd_cnt_reg <= '0;
			wdp_cnt_reg <= '0;
			pulse_reg <= 1'b0;
			fault_reg <= 1'b0;
			fd_reg <= '0;
			watchdog_pulse_out_n <= 1'b1;
			watchdog_fault_out_n <= 1'b1;
		end else if (clk_en) begin
			kick_d_reg <= kick_s;
			if (rst_active_reg) begin // [RL7] [RL15]
				wd_cnt_reg <= '0;
				wdp_cnt_reg <= '0;
				pulse_reg <= 1'b0;
				fault_reg <= 1'b0;
				fd_reg <= '0;
				watchdog_pulse_out_n <= 1'b1;
				watchdog_fault_out_n <= 1'b1;
			end else begin
				wd_cnt_reg <= wd_cnt_next;
				wdp_cnt_reg <= wdp_cnt_next;
				pulse_reg <= pulse_next;
				fault_reg <= fault_next;
				fd_reg <= {fd_reg[ssw_pkg::FAULT_DELAY_CYCLES-2:0], wd_expire}; // [RL17]
				watchdog_pulse_out_n <= ~pulse_next; // [RL11] [RL18]
				watchdog_fault_out_n <= ~fault_next; // [RL11]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Chip-select gating.
	logic ce_hold_reg;
	logic [ssw_pkg::CE_HOLD_W-1:0] ce_hold_cnt_reg;
	wire logic rst_rise = rst_next & ~rst_active_reg;
	wire logic hold_expired =
		(ce_hold_cnt_reg == ssw_pkg::CE_HOLD_W'(ssw_pkg::CE_HOLD_CYCLES - 1));
	wire logic ce_hold_next = rst_rise ? ~ce_in_n
		: (rst_next & ce_hold_reg & ~ce_in_n & ~hold_expired); // [RL19]
	wire logic [ssw_pkg::CE_HOLD_W-1:0] ce_hold_cnt_next =
		(rst_rise || !ce_hold_reg) ? '0 : ce_hold_cnt_reg + 1'b1;
	wire logic ce_out_next = rst_next ? ~ce_hold_next : ce_in_n; // [RL8] [RL22]

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ce_hold_reg <= 1'b0;
			ce_hold_cnt_reg <= '0;
			ce_out_n <= 1'b1;
		end else if (clk_en) begin
			ce_hold_reg <= ce_hold_next;
			ce_hold_cnt_reg <= ce_hold_cnt_next;
			ce_out_n <= ce_out_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	a_reset_inverse: assert property (reset_out == ~reset_out_n) // [RL9]
		else $error("reset outputs are not complementary");
	a_reset_supply_low: assert property (clk_en && below_rst |=> !reset_out_n) // [RL4]
		else $error("reset not asserted while supply is low");
	a_reset_manual: assert property (clk_en && !mr_n_s |=> !reset_out_n) // [RL5]
		else $error("reset not asserted while manual reset is low");
	a_stretch_holds: assert property (
		clk_en && $fell(rst_cause) |=> !reset_out_n [*8]) // [RL6]
		else $error("reset released before stretch time");
	a_wd_reset_high: assert property (
		rst_active_reg && clk_en |=> watchdog_fault_out_n && watchdog_pulse_out_n) // [RL7]
		else $error("watchdog outputs not high during reset");
	a_ce_blocked: assert property (
		clk_en && rst_next && !ce_hold_next |=> ce_out_n) // [RL8]
		else $error("chip select not blocked during reset");
	a_ce_pass: assert property (clk_en && !rst_next |=> ce_out_n == $past(ce_in_n)) // [RL22]
		else $error("chip select not passed out of reset");
	a_ov_flag: assert property (clk_en |=> overvoltage_flag_n == ~$past(ov_s)) // [RL10]
		else $error("overvoltage flag wrong");
	a_fault_follows: assert property (
		clk_en && wd_expire && !rst_active_reg ##1 (clk_en && !rst_active_reg) [*2]
		|=> !watchdog_fault_out_n) // [RL17]
		else $error("fault not low two cycles after pulse fell");
	a_pulse_on_expire: assert property (
		clk_en && wd_expire && !rst_active_reg |=> !watchdog_pulse_out_n) // [RL11]
		else $error("watchdog pulse missing on timeout");
	a_kick_restart: assert property (
		clk_en && kick_edge && !rst_active_reg |=> wd_cnt_reg == '0) // [RL12]
		else $error("kick did not restart watchdog timer");
	a_ce_hold_bound: assert property (
		clk_en && rst_rise && !ce_in_n |=> ##[0:300] ce_out_n) // [RL19]
		else $error("chip select held past window");

	c_reset_stretch: cover property (clk_en && stretch_done);
	c_wd_fault: cover property (clk_en && fault_set && !rst_active_reg);
	c_ce_hold: cover property (clk_en && rst_rise && !ce_in_n);
	c_ext_mode: cover property (mode_ext && below_warn && !below_rst);
endmodule : ssw_top

// >>> design/ssw_pkg.sv
// Constants of the supply supervisor and watchdog block.
// Summary of operation
// RL1 - Threshold-select high selects external programming mode.
// RL2 - Internal mode: early warning precedes reset.
// RL3 - External mode: pins decide warning and reset.
// RL4 - Reset while supply below reset threshold.
// RL5 - Reset while manual reset input low.
// RL6 - Reset stretched 200 ms after release.
// RL7 - Reset clears counters, watchdog outputs high.
// RL8 - Reset blocks chip select, output high.
// RL9 - Active-high reset inverts active-low reset.
// RL10 - Overvoltage flag low above trip, independent.
// RL11 - Kick idle past timeout asserts watchdog outputs.
// RL12 - Any kick edge or pulse restarts timer.
// RL13 - Host kicks every period or ties input.
// RL14 - Default timeout unless alternative period selected.
// RL15 - Supply low disables watchdog, fault high.
// RL16 - Fault stays high while kicks arrive.
// RL17 - Fault falls 70 ns after pulse falls; code rounds up to 2 clocks, 100 ns.
// RL18 - Watchdog pulse low for 1.7 ms.
// RL19 - Chip select held low up to 15 us.
// RL20 - Manual reset held low at least 25 us.
// RL21 - Inputs synchronised, durations from clock prescaler; code leaves ce_in_n unsynchronised and counts chip-select hold in clocks.
// RL22 - Out of reset, chip select passes through.
package ssw_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int TICK_CNT_W = 5;
	localparam int CNT_W = 24;
	localparam int RST_STRETCH_MS = 200;
	localparam int RST_STRETCH_TICKS = RST_STRETCH_MS * 1000000 / TICK_NS;
	localparam int WD_TIMEOUT_MS = 1600;
	localparam int WD_TIMEOUT_TICKS = WD_TIMEOUT_MS * 1000000 / TICK_NS;
	localparam int WD_PULSE_US = 1700;
	localparam int WD_PULSE_TICKS = WD_PULSE_US * 1000 / TICK_NS;
	localparam int CE_HOLD_US = 15;
	localparam int CE_HOLD_CYCLES = CE_HOLD_US * 1000 / CLK_PERIOD_NS;
	localparam int CE_HOLD_W = 9;
	localparam int FAULT_DELAY_NS = 70;
	localparam int FAULT_DELAY_CYCLES = (FAULT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int KICK_MIN_PULSE_NS = 100;
	localparam int SYNC_W = 7;
	localparam logic RST_ACTIVE_INIT = 1'b1;
endpackage : ssw_pkg

// >>> design/ssw_sync.sv
// Two-flop synchroniser, one chain per bit.
`timescale 1ns/1ps
module ssw_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_reg;
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					meta_reg <= INIT[i];
					q[i] <= INIT[i];
				end else if (clk_en) begin
					meta_reg <= d[i];
					q[i] <= meta_reg;
				end
			end
		end
	endgenerate
endmodule : ssw_sync

// >>> design/ssw_prescaler.sv
// Prescaler giving a one-cycle tick every microsecond.
`timescale 1ns/1ps
module ssw_prescaler (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	output logic tick
);
	logic [ssw_pkg::TICK_CNT_W-1:0] cnt_reg;
	wire logic wrap = (cnt_reg == ssw_pkg::TICK_CNT_W'(ssw_pkg::TICK_CYCLES - 1));
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			tick <= 1'b0;
		end else if (clk_en) begin
			cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
			tick <= wrap;
		end
	end
endmodule : ssw_prescaler

// >>> dv/ssw_host_model.sv
// Host side model: watchdog kicks and memory chip select.
`timescale 1ns/1ps
module ssw_host_model (
	input wire logic mclk,
	input wire logic kick_en,
	input wire logic ce_req,
	output logic kick_input,
	output logic ce_in_n
);
	int cnt = 0;
	initial kick_input = 1'b0;
	initial ce_in_n = 1'b1;
	always @(negedge mclk) begin
		ce_in_n <= ~ce_req;
		cnt <= (cnt == 99) ? 0 : cnt + 1;
		if (kick_en && cnt == 99) kick_input <= ~kick_input;
	end
endmodule : ssw_host_model

// >>> dv/test_supply_supervisor_watchdog.sv
// Self-checking testbench of the supply supervisor and watchdog.
`timescale 1ns/1ps
module test_supply_supervisor_watchdog;
	logic mclk, rst_n, clk_en, threshold_select_high, supply_below_reset, supply_below_warn;
	logic early_warning_sense_low, reset_in_low, manual_reset_in_n, kick_input;
	logic overvoltage_sense, timeout_select, ce_in_n, kick_en, ce_req;
	logic [23:0] wd_alt_ticks;
	logic reset_out_n, reset_out, early_power_warning_n, watchdog_pulse_out_n;
	logic watchdog_fault_out_n, overvoltage_flag_n, ce_out_n;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	ssw_top #(.RST_STRETCH_TICKS(24'h00000A), .WD_TIMEOUT_TICKS(24'h000014),
		.WD_PULSE_TICKS(24'h000003)) DUT (.mclk, .rst_n, .clk_en, .threshold_select_high,
		.supply_below_reset, .supply_below_warn, .early_warning_sense_low, .reset_in_low,
		.manual_reset_in_n, .kick_input, .overvoltage_sense, .timeout_select, .wd_alt_ticks,
		.ce_in_n, .reset_out_n, .reset_out, .early_power_warning_n, .watchdog_pulse_out_n,
		.watchdog_fault_out_n, .overvoltage_flag_n, .ce_out_n);
	ssw_host_model host (.mclk, .kick_en, .ce_req, .kick_input, .ce_in_n);
	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			complete_run;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic pick(input int s);
		case (s)
			0: return reset_out_n;
			1: return watchdog_pulse_out_n;
			2: return watchdog_fault_out_n;
			3: return ce_out_n;
			default: return early_power_warning_n;
		endcase
	endfunction : pick
	task automatic wait_for(input int s, input logic v, input int max, output int n);
		n = 0;
		while (pick(s) !== v && n < max) begin
			@(negedge mclk);
			n++;
		end
		check(pick(s), v);
	endtask : wait_for
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_manual;
		int n;
		manual_reset_in_n = 1'b0;
		wait_for(0, 1'b0, 6, n);
		check(n >= 2, 1'b1);
		ce_req = 1'b1;
		repeat (600) @(negedge mclk);
		check(reset_out, 1'b1);
		check(ce_out_n, 1'b1);
		check({watchdog_pulse_out_n, watchdog_fault_out_n}, 2'h3);
		ce_req = 1'b0;
		manual_reset_in_n = 1'b1;
		wait_for(0, 1'b1, 230, n);
		check(n >= 180, 1'b1);
		check(reset_out, 1'b0);
		$display("test manual done");
	endtask : t_manual
	task automatic t_modes;
		int n;
		supply_below_warn = 1'b1;
		wait_for(4, 1'b0, 6, n);
		check(reset_out_n, 1'b1);
		supply_below_warn = 1'b0;
		threshold_select_high = 1'b1;
		overvoltage_sense = 1'b1;
		supply_below_reset = 1'b1;
		repeat (8) @(negedge mclk);
		check(reset_out_n, 1'b1);
		check(early_power_warning_n, 1'b1);
		check(overvoltage_flag_n, 1'b0);
		early_warning_sense_low = 1'b1;
		wait_for(4, 1'b0, 6, n);
		reset_in_low = 1'b1;
		wait_for(0, 1'b0, 6, n);
		check(overvoltage_flag_n, 1'b0);
		{reset_in_low, early_warning_sense_low, supply_below_reset} = 3'h0;
		{threshold_select_high, overvoltage_sense} = 2'h0;
		wait_for(0, 1'b1, 230, n);
		check(overvoltage_flag_n, 1'b1);
		$display("test modes done");
	endtask : t_modes
	task automatic t_supply_ce;
		int n;
		kick_en = 1'b0;
		ce_req = 1'b1;
		repeat (3) @(negedge mclk);
		check(ce_out_n, 1'b0);
		supply_below_reset = 1'b1;
		wait_for(0, 1'b0, 6, n);
		wait_for(3, 1'b1, 320, n);
		check(n >= 290, 1'b1);
		repeat (400) @(negedge mclk);
		check(watchdog_fault_out_n, 1'b1);
		check(reset_out_n, 1'b0);
		{ce_req, supply_below_reset, kick_en} = 3'h1;
		wait_for(0, 1'b1, 230, n);
		$display("test supply done");
	endtask : t_supply_ce
	task automatic t_watchdog;
		int n;
		repeat (1000) @(negedge mclk);
		check(watchdog_fault_out_n, 1'b1);
		kick_en = 1'b0;
		wait_for(1, 1'b0, 440, n);
		check(n >= 250, 1'b1);
		wait_for(2, 1'b0, 4, n);
		check(n, 2);
		wait_for(1, 1'b1, 70, n);
		check(n >= 56 && n <= 60, 1'b1);
		kick_en = 1'b1;
		wait_for(2, 1'b1, 120, n);
		timeout_select = 1'b1;
		kick_en = 1'b0;
		wait_for(1, 1'b0, 130, n);
		$display("test watchdog done");
	endtask : t_watchdog
	// A manual reset seen only while the clock enable is low must leave no trace.
	task automatic t_freeze;
		logic held;
		held = watchdog_pulse_out_n;
		clk_en = 1'b0;
		manual_reset_in_n = 1'b0;
		repeat (40) @(negedge mclk);
		check(reset_out_n, 1'b1);
		check(watchdog_pulse_out_n, held);
		manual_reset_in_n = 1'b1;
		repeat (2) @(negedge mclk);
		clk_en = 1'b1;
		repeat (4) @(negedge mclk);
		check(reset_out_n, 1'b1);
		$display("test freeze done");
	endtask : t_freeze
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int n;
		{mclk, rst_n, threshold_select_high, supply_below_reset, supply_below_warn} = 5'h00;
		{early_warning_sense_low, reset_in_low, overvoltage_sense, timeout_select} = 4'h0;
		{clk_en, manual_reset_in_n, kick_en, ce_req} = 4'hE;
		wd_alt_ticks = 24'h000005;
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		check(reset_out_n, 1'b0);
		wait_for(0, 1'b1, 260, n);
		t_manual;
		t_modes;
		t_supply_ce;
		t_watchdog;
		t_freeze;
		complete_run;
	end
endmodule : test_supply_supervisor_watchdog
